/* File: src/qoc_ctrl_status_seq.v */
// Control, status and reset-to-ready sequencer of a quad optical transceiver
`timescale 1ns/100ps
`include "qoc_defines.vh"

module qoc_ctrl_status_seq
#(
   parameter NCH = 4,
   parameter READY_HIGH_CYC = `QOC_READY_HIGH_MS * 1000 * `QOC_CLK_MHZ,
   parameter READY_LOW_CYC = `QOC_READY_LOW_MS * 1000 * `QOC_CLK_MHZ,
   parameter RST_MIN_CYC = `QOC_RST_MIN_US * `QOC_CLK_MHZ,
   parameter SELFTEST_CYC = `QOC_SELFTEST_CYC
)
(
   input wire sys_clk,
   input wire rst,
   input wire supply_good,
   input wire reset_line_in,
   output wire reset_line_out,
   output wire reset_line_oe,
   output reg ready_out,
   input wire tx_global_enable_pin,
   input wire rx_global_enable_pin,
   input wire loss_squelch_enable,
   input wire [NCH-1:0] tx_laser_fault,
   input wire [NCH-1:0] rx_light_raw,
   output wire [NCH-1:0] tx_channel_enable,
   output wire [NCH-1:0] rx_channel_enable,
   output wire [NCH-1:0] rx_data_mute,
   output reg laser_fault_out,
   output reg rx_light_detect_ch0,
   output reg rx_light_detect_ch1,
   output reg rx_light_detect_ch2,
   output reg rx_light_detect_ch3,
   input wire serial_select_n,
   output wire serial_selected,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp
);

   localparam CW = 32;
   localparam [2:0] ST_RESET = `QOC_ST_RESET;
   localparam [2:0] ST_SELFTEST = `QOC_ST_SELFTEST;
   localparam [2:0] ST_RDY_HIGH = `QOC_ST_RDY_HIGH;
   localparam [2:0] ST_RDY_LOW = `QOC_ST_RDY_LOW;
   localparam [2:0] ST_RUN = `QOC_ST_RUN;
   localparam [7:0] CTRL_DEFAULT = `QOC_CTRL_RESET;

   // Two-flop synchronisers for all pin inputs except serial_select_n
   reg [4+3*NCH-1:0] sync1_r;
   reg [4+3*NCH-1:0] sync2_r;
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         sync1_r <= {(4+3*NCH){1'b0}};
         sync2_r <= {(4+3*NCH){1'b0}};
      end
      else
      begin
         sync1_r <= {supply_good, reset_line_in, tx_global_enable_pin,
                     rx_global_enable_pin, tx_laser_fault, rx_light_raw,
                     {NCH{loss_squelch_enable}}};
         sync2_r <= sync1_r;
      end
   end

   wire supply_ok = sync2_r[4+3*NCH-1];
   wire line_high = sync2_r[4+3*NCH-2];
   wire tx_pin = sync2_r[4+3*NCH-3];
   wire rx_pin = sync2_r[4+3*NCH-4];
   wire [NCH-1:0] fault_s = sync2_r[3*NCH-1:2*NCH];
   wire [NCH-1:0] light_s = sync2_r[2*NCH-1:NCH];
   wire squelch_s = sync2_r[0];

   // Enable registers written by software, and the fault latch set by faults and cleared on read
   reg [NCH-1:0] tx_en_reg_r;
   reg [NCH-1:0] rx_en_reg_r;
   reg [NCH-1:0] fault_latch_r;
   reg [NCH-1:0] fault_latch_nxt;

   // Supply monitor drives the shared line low until the supply is good
   assign reset_line_out = 1'b0;
   assign reset_line_oe = ~supply_ok;

   // Low time on the line must reach the minimum to count as a reset
   reg [CW-1:0] low_cnt_r;
   reg line_reset_r;
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         low_cnt_r <= {CW{1'b0}};
         line_reset_r <= 1'b1;
      end
      else if (line_high)
      begin
         low_cnt_r <= {CW{1'b0}};
         line_reset_r <= 1'b0;
      end
      else
      begin
         if (low_cnt_r < RST_MIN_CYC[CW-1:0])
            low_cnt_r <= low_cnt_r + 1'b1;
         if (low_cnt_r >= RST_MIN_CYC[CW-1:0] - 1'b1)
            line_reset_r <= 1'b1;
      end
   end

   wire any_reset = line_reset_r | ~supply_ok;

   // Reset-to-ready sequencer
   reg [2:0] state_r;
   reg [CW-1:0] cnt_r;
   reg load_defaults_r;
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_r <= ST_RESET;
         cnt_r <= {CW{1'b0}};
         ready_out <= 1'b0;
         load_defaults_r <= 1'b0;
      end
      else if (any_reset)
      begin
         state_r <= ST_RESET;
         cnt_r <= {CW{1'b0}};
         ready_out <= 1'b0;
         load_defaults_r <= 1'b0;
      end
      else
      begin
         load_defaults_r <= 1'b0;
         case (state_r)
            ST_RESET:
            begin
               state_r <= ST_SELFTEST;
               ready_out <= 1'b1;
               cnt_r <= {CW{1'b0}};
            end
            ST_SELFTEST:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == SELFTEST_CYC[CW-1:0] - 1'b1)
               begin
                  load_defaults_r <= 1'b1;
                  // High phase counts from zero after self-test
                  cnt_r <= {CW{1'b0}};
                  state_r <= ST_RDY_HIGH;
               end
            end
            ST_RDY_HIGH:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == READY_HIGH_CYC[CW-1:0] - 1'b1)
               begin
                  ready_out <= 1'b0;
                  cnt_r <= {CW{1'b0}};
                  state_r <= ST_RDY_LOW;
               end
            end
            ST_RDY_LOW:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == READY_LOW_CYC[CW-1:0] - 1'b1)
               begin
                  ready_out <= 1'b1;
                  state_r <= ST_RUN;
               end
            end
            default:
            begin
               ready_out <= 1'b1;
               state_r <= ST_RUN;
            end
         endcase
      end
   end

   wire running = (state_r == ST_RUN);

   // Channel enables
   assign tx_channel_enable = {NCH{tx_pin}} & tx_en_reg_r;
   assign rx_channel_enable = {NCH{rx_pin}} & rx_en_reg_r;
   assign serial_selected = ~serial_select_n;

   // Receive mute: disabled channel or squelch with no light
   assign rx_data_mute = ~rx_channel_enable |
                         ({NCH{squelch_s}} & ~light_s);

   // Live fault of enabled channels, only in ST_RUN once the ready low pulse has ended
   wire [NCH-1:0] fault_live = fault_s & tx_channel_enable & {NCH{running}};

   wire [NCH-1:0] detect = light_s | ~rx_channel_enable;
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         laser_fault_out <= 1'b0;
         rx_light_detect_ch0 <= 1'b1;
         rx_light_detect_ch1 <= 1'b1;
         rx_light_detect_ch2 <= 1'b1;
         rx_light_detect_ch3 <= 1'b1;
      end
      else
      begin
         laser_fault_out <= |fault_live;
         rx_light_detect_ch0 <= detect[0];
         rx_light_detect_ch1 <= detect[1];
         rx_light_detect_ch2 <= detect[2];
         rx_light_detect_ch3 <= detect[3];
      end
   end

   // AHB-Lite slave, zero wait states
   reg ap_valid_r;
   reg ap_write_r;
   reg [7:0] ap_addr_r;
   wire ap_take = hsel & hready & (htrans == `QOC_HTRANS_NONSEQ);
   assign hreadyout = 1'b1;
   assign hresp = `QOC_HRESP_OKAY;

   function [31:0] rd_mux;
      input [7:0] a;
      begin
         if (a == `QOC_ADDR_CTRL)
            rd_mux = {24'h000000, rx_en_reg_r, tx_en_reg_r};
         else if (a == `QOC_ADDR_STATUS)
            rd_mux = {20'h00000, state_r, ready_out, detect,
                      laser_fault_out, squelch_s, rx_pin, tx_pin};
         else if (a == `QOC_ADDR_FAULT_LATCH)
            rd_mux = {28'h0000000, fault_latch_r};
         else if (a == `QOC_ADDR_FAULT_LIVE)
            rd_mux = {28'h0000000, fault_live};
         else
            rd_mux = 32'h00000000;
      end
   endfunction

   wire rd_latch = ap_take & ~hwrite &
                   (haddr[7:0] == `QOC_ADDR_FAULT_LATCH) &
                   (haddr[31:8] == 24'h000000);

   always @*
   begin
      // Set wins over read clear
      fault_latch_nxt = fault_latch_r;
      if (rd_latch)
         fault_latch_nxt = {NCH{1'b0}};
      fault_latch_nxt = fault_latch_nxt | fault_live;
   end

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_addr_r <= 8'h00;
         hrdata <= 32'h00000000;
         tx_en_reg_r <= CTRL_DEFAULT[`QOC_TX_EN_LSB +: NCH];
         rx_en_reg_r <= CTRL_DEFAULT[`QOC_RX_EN_LSB +: NCH];
         fault_latch_r <= {NCH{1'b0}};
      end
      else
      begin
         fault_latch_r <= fault_latch_nxt;
         ap_valid_r <= ap_take & (haddr[31:8] == 24'h000000);
         ap_write_r <= hwrite;
         ap_addr_r <= haddr[7:0];
         if (ap_take & ~hwrite & (haddr[31:8] == 24'h000000))
            hrdata <= rd_mux(haddr[7:0]);
         else if (ap_take)
            hrdata <= 32'h00000000;
         if (load_defaults_r)
         begin
            tx_en_reg_r <= CTRL_DEFAULT[`QOC_TX_EN_LSB +: NCH];
            rx_en_reg_r <= CTRL_DEFAULT[`QOC_RX_EN_LSB +: NCH];
         end
         else if (ap_valid_r & ap_write_r & (ap_addr_r == `QOC_ADDR_CTRL))
         begin
            tx_en_reg_r <= hwdata[`QOC_TX_EN_LSB +: NCH];
            rx_en_reg_r <= hwdata[`QOC_RX_EN_LSB +: NCH];
         end
      end
   end

endmodule

/* File: src/qoc_defines.vh */
// Constants for the quad optic control and status sequencer
`ifndef QOC_DEFINES_VH
`define QOC_DEFINES_VH

`define QOC_CLK_MHZ 250
`define QOC_READY_HIGH_MS 55
`define QOC_READY_LOW_MS 35
`define QOC_READY_MAX_MS 100
`define QOC_RST_MIN_US 20
`define QOC_SELFTEST_CYC 16

`define QOC_ADDR_CTRL 8'h00
`define QOC_ADDR_STATUS 8'h04
`define QOC_ADDR_FAULT_LATCH 8'h08
`define QOC_ADDR_FAULT_LIVE 8'h0C

`define QOC_TX_EN_LSB 0
`define QOC_RX_EN_LSB 4
`define QOC_CTRL_RESET 8'hFF

`define QOC_HTRANS_NONSEQ 2'h2
`define QOC_HSIZE_WORD 3'h2
`define QOC_HRESP_OKAY 1'h0

`define QOC_ST_RESET 3'h0
`define QOC_ST_SELFTEST 3'h1
`define QOC_ST_RDY_HIGH 3'h2
`define QOC_ST_RDY_LOW 3'h3
`define QOC_ST_RUN 3'h4

`endif

/* File: tb/qoc_seq_properties.sv */
// Port-level checks of the control, status and ready sequencer
`timescale 1ns/100ps
module qoc_seq_props
#(parameter READY_LOW_CYC = 30)
(
   input wire sys_clk,
   input wire rst,
   input wire supply_good,
   input wire reset_line_in,
   input wire reset_line_out,
   input wire reset_line_oe,
   input wire ready_out,
   input wire tx_global_enable_pin,
   input wire rx_global_enable_pin,
   input wire [3:0] tx_laser_fault,
   input wire [3:0] rx_light_raw,
   input wire [3:0] tx_channel_enable,
   input wire [3:0] rx_channel_enable,
   input wire laser_fault_out,
   input wire rx_light_detect_ch0,
   input wire serial_select_n,
   input wire serial_selected
);
   int lo_cnt_r = 0;
   reg seen_hi_r;
   reg run_r;
   wire src_rst = rst || !supply_good || !reset_line_in;
   // Only a rise after a high phase of this run ends the low pulse
   always @(posedge sys_clk)
   begin
      lo_cnt_r <= ready_out ? 0 : lo_cnt_r + 1;
      seen_hi_r <= src_rst ? 1'b0 : (seen_hi_r || ready_out);
      run_r <= src_rst ? 1'b0 : (run_r || (ready_out && lo_cnt_r != 0
         && seen_hi_r));
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_ready_low_width: assert property ($rose(ready_out) && seen_hi_r |->
      lo_cnt_r == READY_LOW_CYC) else $error("ready low pulse width");
   a_ready_on_release: assert property ($fell(rst) && supply_good |->
      ##[1:12] ready_out) else $error("ready not raised after reset");
   a_ready_final_by: assert property ($fell(rst) && supply_good |->
      ##[85:120] ($rose(ready_out) && seen_hi_r)) else $error("late ready");
   a_tx_pin_gate: assert property (!tx_global_enable_pin [*3] |->
      tx_channel_enable == 4'h0) else $error("tx enabled with pin low");
   a_rx_pin_gate: assert property (!rx_global_enable_pin [*3] |->
      rx_channel_enable == 4'h0) else $error("rx enabled with pin low");
   a_detect_forced_high: assert property (rx_light_detect_ch0 ||
      $past(rx_channel_enable[0])) else $error("detect low while disabled");
   a_detect_follows: assert property ($past(rx_channel_enable[0]) |->
      rx_light_detect_ch0 == $past(rx_light_raw[0], 3))
      else $error("detect differs from light");
   a_fault_summary: assert property (run_r && $past(run_r, 4) |->
      laser_fault_out == |($past(tx_laser_fault, 3) &
      $past(tx_channel_enable))) else $error("fault summary wrong");
   a_select_low: assert property (serial_selected == !serial_select_n)
      else $error("select polarity");
   a_brownout_pull: assert property (!supply_good [*3] |->
      reset_line_oe && !reset_line_out) else $error("reset line not pulled");
endmodule

/* File: tb/qoc_host_model.sv */
// Host side model: the shared open-collector reset line
`timescale 1ns/100ps
module qoc_host_model
#(parameter MIN_LOW = 10)
(
   input wire sys_clk,
   input wire hold_req,
   input wire reset_line_oe,
   output wire reset_line_in
);
   int low_cnt_r = 0;
   // A hold request is stretched to at least MIN_LOW cycles
   always @(posedge sys_clk)
      low_cnt_r <= hold_req ? MIN_LOW : (low_cnt_r > 0 ? low_cnt_r - 1 : 0);
   // Pulled up; low while either party drives it
   assign reset_line_in = !(hold_req || low_cnt_r > 0 || reset_line_oe);
endmodule

/* File: tb/test_quad_optic_ctrl_status_seq.sv */
// Testbench of the control, status and ready sequencer
`timescale 1ns/100ps
`include "qoc_defines.vh"
module test_quad_optic_ctrl_status_seq;
   localparam LOW = 30;
   reg sys_clk = 0, rst = 1, supply_good = 1, hold_req = 0, hwrite = 0;
   reg tx_global_enable_pin = 1, rx_global_enable_pin = 1;
   reg loss_squelch_enable = 1, serial_select_n = 1;
   reg [3:0] tx_laser_fault = 4'h0, rx_light_raw = 4'h1;
   reg [31:0] haddr = 32'h0, hwdata = 32'h0;
   reg [1:0] htrans = 2'h0;
   wire reset_line_in, reset_line_out, reset_line_oe, ready_out, hresp;
   wire laser_fault_out, hreadyout, serial_selected;
   wire rx_light_detect_ch0, rx_light_detect_ch1;
   wire rx_light_detect_ch2, rx_light_detect_ch3;
   wire [3:0] tx_channel_enable, rx_channel_enable, rx_data_mute;
   wire [31:0] hrdata;
   wire [3:0] det = {rx_light_detect_ch3, rx_light_detect_ch2,
      rx_light_detect_ch1, rx_light_detect_ch0};
   int err_total = 0, tests_run = 0, n;
   logic [31:0] rd;
   qoc_ctrl_status_seq #(.READY_HIGH_CYC(50), .READY_LOW_CYC(LOW),
      .RST_MIN_CYC(8)) i_dut (.sys_clk, .rst, .supply_good, .reset_line_in,
      .reset_line_out, .reset_line_oe, .ready_out, .tx_global_enable_pin,
      .rx_global_enable_pin, .loss_squelch_enable, .tx_laser_fault,
      .rx_light_raw, .tx_channel_enable, .rx_channel_enable, .rx_data_mute,
      .laser_fault_out, .rx_light_detect_ch0, .rx_light_detect_ch1,
      .rx_light_detect_ch2, .rx_light_detect_ch3, .serial_select_n,
      .serial_selected, .hsel(1'b1), .haddr, .htrans, .hwrite,
      .hsize(`QOC_HSIZE_WORD), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp);
   qoc_host_model #(.MIN_LOW(10)) i_host (.sys_clk, .hold_req,
      .reset_line_oe, .reset_line_in);
   initial
      forever #2 sys_clk = ~sys_clk;
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tick(input int c);
      int k;
      k = 0;
      do
      begin
         @(posedge sys_clk);
         k++;
      end
      while ((c == 0 && hreadyout !== 1'b1 && k < 100) || k < c);
      if (k >= 100)
      begin
         err_total++;
         end_sim;
      end
   endtask
   task wait_rdy(input logic v);
      n = 0;
      while (ready_out !== v)
      begin
         @(posedge sys_clk);
         n++;
         if (n > 1000)
         begin
            err_total++;
            end_sim;
         end
      end
   endtask
   // One word transfer; rd holds read data taken at the data phase end
   task bus(input [31:0] a, input w, input [31:0] d);
      haddr <= a;
      hwrite <= w;
      htrans <= `QOC_HTRANS_NONSEQ;
      tick(0);
      htrans <= 2'h0;
      hwdata <= d;
      tick(0);
      rd = hrdata;
   endtask
   initial
   begin
      tick(12);
      rst <= 1'b0;
      wait_rdy(1);
      wait_rdy(0);
      wait_rdy(1);
      chk(n, LOW);
      $display("ready sequence test done");
      bus(`QOC_ADDR_CTRL, 1, 32'h5E);
      tick(4);
      chk(tx_channel_enable, 4'hE);
      chk(rx_channel_enable, 4'h5);
      chk(det, 4'hB);
      chk(rx_data_mute, 4'hE);
      loss_squelch_enable <= 1'b0;
      rx_light_raw <= 4'h0;
      tick(4);
      chk(det, 4'hA);
      chk(rx_data_mute, 4'hA);
      loss_squelch_enable <= 1'b1;
      rx_light_raw <= 4'h1;
      bus(`QOC_ADDR_CTRL, 0, 32'h0);
      chk(rd, 32'h5E);
      bus(32'h40, 1, 32'hFFFFFFFF);
      bus(32'h40, 0, 32'h0);
      chk(rd, 32'h0);
      tx_global_enable_pin <= 1'b0;
      rx_global_enable_pin <= 1'b0;
      serial_select_n <= 1'b0;
      tick(4);
      chk(tx_channel_enable, 4'h0);
      chk(rx_channel_enable, 4'h0);
      chk(det, 4'hF);
      chk(serial_selected, 1'b1);
      tx_global_enable_pin <= 1'b1;
      rx_global_enable_pin <= 1'b1;
      tx_laser_fault <= 4'h1;
      tick(4);
      chk(laser_fault_out, 1'b0);
      tx_laser_fault <= 4'h2;
      tick(4);
      chk(laser_fault_out, 1'b1);
      bus(`QOC_ADDR_FAULT_LIVE, 0, 32'h0);
      chk(rd, 32'h2);
      tx_laser_fault <= 4'h0;
      tick(4);
      chk(laser_fault_out, 1'b0);
      bus(`QOC_ADDR_FAULT_LATCH, 0, 32'h0);
      chk(rd, 32'h2);
      bus(`QOC_ADDR_FAULT_LATCH, 0, 32'h0);
      chk(rd, 32'h0);
      $display("enable and fault test done");
      hold_req <= 1'b1;
      tick(1);
      hold_req <= 1'b0;
      wait_rdy(0);
      wait_rdy(1);
      tx_laser_fault <= 4'h2;
      tick(4);
      chk(laser_fault_out, 1'b0);
      tx_laser_fault <= 4'h0;
      wait_rdy(0);
      wait_rdy(1);
      bus(`QOC_ADDR_CTRL, 0, 32'h0);
      chk(rd, 32'hFF);
      supply_good <= 1'b0;
      tick(5);
      chk(reset_line_oe, 1'b1);
      chk(ready_out, 1'b0);
      $display("reset line test done");
      end_sim;
   end
endmodule
bind qoc_ctrl_status_seq qoc_seq_props #(.READY_LOW_CYC(READY_LOW_CYC)) i_props
   (.sys_clk, .rst, .supply_good, .reset_line_in, .reset_line_out,
   .reset_line_oe, .ready_out, .tx_global_enable_pin, .rx_global_enable_pin,
   .tx_laser_fault, .rx_light_raw, .tx_channel_enable, .rx_channel_enable,
   .laser_fault_out, .rx_light_detect_ch0, .serial_select_n,
   .serial_selected);
